// [bench/mfi_ctrl_bench.sv]
// Purpose: register level test of the field interrupt controller
// Assumes: limits 0x01 and 0x02 give compare levels 16 and 32
// Notes: checks go through registers or the host pin view, except the pin oe checks on the raw enables
`timescale 1ns/1ps
`default_nettype none
module mfi_ctrl_bench;
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic mv = 1'b0;
	logic [12:0] mx = 13'h0000;
	logic [12:0] my = 13'h0000;
	logic [14:0] mz = 15'h0000;
	logic [13:0] mr = 14'h0000;
	logic [2:0] mo = 3'h0;
	logic [7:0] ra = 8'h00;
	logic [7:0] wd = 8'h00;
	logic we = 1'b0;
	logic re = 1'b0;
	logic xe = 1'b0;
	logic [7:0] rdata;
	logic ev, ev_oe, rdy, rdy_oe, ev_lvl, rdy_lvl;
	int fail_count = 0;
	int total_checks = 0;
	logic [12:0] tx [5] = '{13'h000F, 13'h0021, 13'h0000, 13'h0010, 13'h0010};
	logic [12:0] ty [5] = '{13'h0010, 13'h000F, 13'h1FFF, 13'h0020, 13'h0010};
	logic [14:0] tz [5] = '{15'h0021, 15'h0010, 15'h0010, 15'h0000, 15'h0010};
	logic [2:0] to [5] = '{3'h0, 3'h0, 3'h1, 3'h4, 3'h0};
	logic [7:0] te [5] = '{8'h81, 8'h14, 8'h44, 8'h48, 8'h00};

	mfi_ctrl uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .meas_valid_i(mv), .meas_x_i(mx), .meas_y_i(my),
		.meas_z_i(mz), .meas_res_i(mr), .meas_ovf_i(mo), .reg_addr_i(ra), .reg_wr_i(we), .reg_wdata_i(wd),
		.reg_rd_i(re), .xfer_end_i(xe), .reg_rdata_o(rdata), .field_x_value_o(), .field_y_value_o(),
		.field_z_value_o(), .plate_resistance_value_o(), .event_pin_o(ev), .event_pin_oe_o(ev_oe),
		.sample_ready_pin_o(rdy), .sample_ready_pin_oe_o(rdy_oe));
	mfi_host_pin ev_host (.clk_i(clk_i), .pin_i(ev), .oe_i(ev_oe), .level_o(ev_lvl));
	mfi_host_pin rdy_host (.clk_i(clk_i), .pin_i(rdy), .oe_i(rdy_oe), .level_o(rdy_lvl));

	initial begin
		forever #10 clk_i = ~clk_i;
	end

	task automatic give_verdict();
		if (fail_count == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : give_verdict

	task automatic tick();
		@(posedge clk_i);
		#1;
	endtask : tick

	task automatic check(input string nm, input logic [7:0] exp, input logic [7:0] got);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %s exp %h got %h", nm, exp, got);
		end
	endtask : check

	// one idle edge first so a strobe is never lowered and raised in one step
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		tick();
		ra = a;
		wd = d;
		we = 1'b1;
		tick();
		we = 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		tick();
		ra = a;
		re = 1'b1;
		tick();
		re = 1'b0;
		check($sformatf("reg %h", a), exp, rdata);
	endtask : rd

	task automatic meas(input logic [12:0] x, input logic [12:0] y, input logic [14:0] z, input logic [2:0] ov);
		tick();
		mx = x;
		my = y;
		mz = z;
		mo = ov;
		mv = 1'b1;
		tick();
		mv = 1'b0;
	endtask : meas

	task automatic end_xfer();
		tick();
		xe = 1'b1;
		tick();
		xe = 1'b0;
	endtask : end_xfer

	initial begin
		repeat (5000) @(posedge clk_i);
		fail_count++;
		$display("[ERR] run exp done got hang");
		give_verdict();
	end

	initial begin
		repeat (10) @(posedge clk_i);
		#1;
		sys_rst_i = 1'b0;
		check("pin oe", 8'h00, {6'h00, ev_oe, rdy_oe});
		rd(8'h4D, 8'h3F);
		rd(8'h4E, 8'h05);
		rd(8'h4A, 8'h02);
		rd(8'h60, 8'h00);
		wr(8'h49, 8'hFF);
		rd(8'h49, 8'h00);
		meas(13'h1F9C, 13'h0000, 15'h0000, 3'h0);
		rd(8'h4A, 8'h02);
		rd(8'h48, 8'h01);
		wr(8'h4E, 8'hC5);
		check("ready pin", 8'h01, {7'h00, rdy_lvl});
		wr(8'h4D, 8'h3E);
		meas(13'h1F9C, 13'h0000, 15'h0000, 3'h0);
		check("event pin", 8'h01, {7'h00, ev_lvl});
		rd(8'h4A, 8'h03);
		check("event pin", 8'h00, {7'h00, ev_lvl});
		rd(8'h4A, 8'h02);
		rd(8'h43, 8'hFC);
		end_xfer();
		check("ready pin", 8'h00, {7'h00, rdy_lvl});
		rd(8'h48, 8'h00);
		meas(13'h0000, 13'h0000, 15'h0000, 3'h1);
		rd(8'h4A, 8'h02);
		wr(8'h4F, 8'h01);
		wr(8'h50, 8'h02);
		wr(8'h4D, 8'h40);
		wr(8'h4A, 8'h00);
		mr = 14'h2A5B;
		for (int i = 0; i < 5; i++) begin
			meas(tx[i], ty[i], tz[i], to[i]);
			check("event pin", {7'h00, |te[i]}, {7'h00, ev_lvl});
			rd(8'h4A, te[i]);
		end
		rd(8'h44, 8'h80);
		rd(8'h49, 8'hA9);
		rd(8'h48, 8'h6D);
		wr(8'h4A, 8'h02);
		wr(8'h4D, 8'h3E);
		meas(13'h0000, 13'h0000, 15'h0000, 3'h0);
		wr(8'h4D, 8'h3F);
		meas(13'h0000, 13'h0000, 15'h0000, 3'h0);
		check("event pin", 8'h00, {7'h00, ev_lvl});
		rd(8'h4A, 8'h02);
		wr(8'h4E, 8'hC0);
		check("event pin", 8'h01, {7'h00, ev_lvl});
		check("ready pin", 8'h00, {7'h00, rdy_lvl});
		wr(8'h4E, 8'h00);
		check("pin oe", 8'h00, {6'h00, ev_oe, rdy_oe});
		give_verdict();
	end
endmodule : mfi_ctrl_bench
`default_nettype wire

// [bench/mfi_ctrl_props.sv]
// Purpose: port assertions for the field interrupt controller
// Assumes: one clock domain, bound onto mfi_ctrl
// Notes: register contents are left to the bench
`timescale 1ns/1ps
`default_nettype none
module mfi_ctrl_props (
	// clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// inputs watched
	input wire logic meas_valid_i,
	input wire logic [mfi_pkg::XY_W-1:0] meas_x_i,
	input wire logic [mfi_pkg::RES_W-1:0] meas_res_i,
	input wire logic [2:0] meas_ovf_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic xfer_end_i,
	// outputs watched
	input wire logic [7:0] reg_rdata_o,
	input wire logic [mfi_pkg::XY_W-1:0] field_x_value_o,
	input wire logic [mfi_pkg::Z_W-1:0] field_z_value_o,
	input wire logic [mfi_pkg::RES_W-1:0] plate_resistance_value_o,
	input wire logic event_pin_o,
	input wire logic event_pin_oe_o,
	input wire logic sample_ready_pin_o,
	input wire logic sample_ready_pin_oe_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	chk_pins_float_rst: assert property (disable iff (1'b0) sys_rst_i |=> !event_pin_oe_o && !sample_ready_pin_oe_o)
		else $error("pin driven after reset");
	chk_x_saturate: assert property (meas_valid_i && meas_ovf_i[0] |=> field_x_value_o == mfi_pkg::XY_OVF_MARK)
		else $error("x not saturated");
	chk_z_saturate: assert property (meas_valid_i && meas_ovf_i[2] |=> field_z_value_o == mfi_pkg::Z_OVF_MARK)
		else $error("z not saturated");
	chk_x_store: assert property (meas_valid_i && !meas_ovf_i[0] |=> field_x_value_o == $past(meas_x_i))
		else $error("x not stored");
	chk_res_store: assert property (meas_valid_i |=> plate_resistance_value_o == $past(meas_res_i))
		else $error("resistance not stored");
	chk_data_hold: assert property (!meas_valid_i |=> $stable(field_z_value_o))
		else $error("data changed without measurement");
	chk_event_hold: assert property (!meas_valid_i && !reg_rd_i && !reg_wr_i |=> $stable(event_pin_o))
		else $error("event pin changed without cause");
	chk_ready_hold: assert property (!meas_valid_i && !xfer_end_i && !reg_wr_i |=> $stable(sample_ready_pin_o))
		else $error("ready pin changed without cause");
	chk_unmapped_zero: assert property (reg_rd_i && reg_addr_i > mfi_pkg::ADDR_UPPER_LIMIT |=> reg_rdata_o == 8'h00)
		else $error("unmapped read not zero");

	cov_overflow: cover property (meas_valid_i && |meas_ovf_i);
	cov_status_read: cover property (reg_rd_i && reg_addr_i == mfi_pkg::ADDR_EVENT_STATUS);
	cov_xfer_end: cover property (xfer_end_i);
endmodule : mfi_ctrl_props
bind mfi_ctrl mfi_ctrl_props chk (
	.clk_i(clk_i),
	.sys_rst_i(sys_rst_i),
	.meas_valid_i(meas_valid_i),
	.meas_x_i(meas_x_i),
	.meas_res_i(meas_res_i),
	.meas_ovf_i(meas_ovf_i),
	.reg_addr_i(reg_addr_i),
	.reg_wr_i(reg_wr_i),
	.reg_rd_i(reg_rd_i),
	.xfer_end_i(xfer_end_i),
	.reg_rdata_o(reg_rdata_o),
	.field_x_value_o(field_x_value_o),
	.field_z_value_o(field_z_value_o),
	.plate_resistance_value_o(plate_resistance_value_o),
	.event_pin_o(event_pin_o),
	.event_pin_oe_o(event_pin_oe_o),
	.sample_ready_pin_o(sample_ready_pin_o),
	.sample_ready_pin_oe_o(sample_ready_pin_oe_o)
);
`default_nettype wire

// [bench/mfi_host_pin.sv]
// Purpose: host side view of one interrupt pin
// Assumes: no pull resistor on the trace
// Notes: a floating pin shows the inverse of its last driven level
`timescale 1ns/1ps
`default_nettype none
module mfi_host_pin (
	// pin from the device
	input wire logic clk_i,
	input wire logic pin_i,
	input wire logic oe_i,
	// level the host samples
	output logic level_o
);
	logic last;
	always_ff @(posedge clk_i) begin
		if (oe_i) begin
			last <= pin_i;
		end
	end
	// an undriven trace must not pass for a quiet driven pin
	assign level_o = oe_i ? pin_i : ~last;
endmodule : mfi_host_pin
`default_nettype wire

// [design/mfi_cmp.sv]
// Purpose: signed threshold comparison of the three field axes
// Assumes: values are the ones about to be stored
// Notes: x and y saturation marker never counts as below
`timescale 1ns/1ps
`default_nettype none
module mfi_cmp (
	// comparison port
	mfi_cmp_if.cmp cmp_if
);

	function automatic logic signed [mfi_pkg::CMP_W-1:0] mfi_scale(input logic [7:0] thr);
		mfi_scale = {{(mfi_pkg::CMP_W-8-mfi_pkg::THR_SHIFT){thr[7]}}, thr, 4'h0};
	endfunction : mfi_scale

	function automatic logic signed [mfi_pkg::CMP_W-1:0] mfi_ext_xy(input logic [mfi_pkg::XY_W-1:0] v);
		mfi_ext_xy = {{(mfi_pkg::CMP_W-mfi_pkg::XY_W){v[mfi_pkg::XY_W-1]}}, v};
	endfunction : mfi_ext_xy

	logic signed [mfi_pkg::CMP_W-1:0] lo;
	logic signed [mfi_pkg::CMP_W-1:0] hi;
	logic signed [mfi_pkg::CMP_W-1:0] zs;

	always_comb begin
		lo = mfi_scale(cmp_if.low_thr);
		hi = mfi_scale(cmp_if.high_thr);
		zs = {{(mfi_pkg::CMP_W-mfi_pkg::Z_W){cmp_if.z[mfi_pkg::Z_W-1]}}, cmp_if.z};
		cmp_if.below[0] = (mfi_ext_xy(cmp_if.x) < lo) && (cmp_if.x != mfi_pkg::XY_OVF_MARK);
		cmp_if.below[1] = (mfi_ext_xy(cmp_if.y) < lo) && (cmp_if.y != mfi_pkg::XY_OVF_MARK);
		cmp_if.below[2] = zs < lo;
		cmp_if.above[0] = mfi_ext_xy(cmp_if.x) > hi;
		cmp_if.above[1] = mfi_ext_xy(cmp_if.y) > hi;
		cmp_if.above[2] = zs > hi;
	end

endmodule : mfi_cmp
`default_nettype wire

// [design/mfi_ctrl.sv]
// Purpose: interrupt controller of a three-axis magnetic field sensor
// Assumes: host register port already decoded from the serial link
// Notes: one measurement set arrives as a one-cycle pulse
//        no shadow registers, so a set stored during a burst read can mix bytes
//        data overrun is not flagged
//        flags are held in flops; the pins are plain decodes of them
//
// Functional notes
// - four interrupt engines, each separately enabled
// - enabled condition sets its status flag
// - event pin active only with event enable
// - threshold and overflow to event pin, ready separate
// - per-axis threshold enables, active low, reset disabled
// - shared overflow event, enable bit defaults off
// - ready pin driven only with its enable
// - flags update together with data store
// - status in event_status, ready at sample_ready_and_resistance_low bit0
// - disabled event cleared at next measurement
// - non-latched follows condition, latched cleared by read
// - one latch mode bit, reset latched
// - ready always non-latched, cleared after readout
// - per-pin polarity bits, default active high
// - push-pull when enabled, high impedance otherwise
// - ready raised after full set stored
// - below lower limit times sixteen sets low
// - x and y saturation marker never raises low event
// - above upper limit times sixteen sets high
// - overflowed axis stored as most negative value
// - overflow flag when any axis out of range
// - ready cleared when data read transfer ends
// - all comparisons signed two's complement
`timescale 1ns/1ps
`default_nettype none
module mfi_ctrl (
	// clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,

	// measurement set from the conversion side
	input wire logic meas_valid_i,
	input wire logic [mfi_pkg::XY_W-1:0] meas_x_i,
	input wire logic [mfi_pkg::XY_W-1:0] meas_y_i,
	input wire logic [mfi_pkg::Z_W-1:0] meas_z_i,
	input wire logic [mfi_pkg::RES_W-1:0] meas_res_i,
	input wire logic [2:0] meas_ovf_i,

	// host register port
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_rd_i,
	input wire logic xfer_end_i,
	output logic [7:0] reg_rdata_o,

	// stored field data
	output logic [mfi_pkg::XY_W-1:0] field_x_value_o,
	output logic [mfi_pkg::XY_W-1:0] field_y_value_o,
	output logic [mfi_pkg::Z_W-1:0] field_z_value_o,
	output logic [mfi_pkg::RES_W-1:0] plate_resistance_value_o,

	// event pin
	output logic event_pin_o,
	output logic event_pin_oe_o,

	// sample ready pin
	output logic sample_ready_pin_o,
	output logic sample_ready_pin_oe_o
);

	typedef struct packed {
		logic [mfi_pkg::XY_W-1:0] x;
		logic [mfi_pkg::XY_W-1:0] y;
		logic [mfi_pkg::Z_W-1:0] z;
		logic [mfi_pkg::RES_W-1:0] res;
		logic ready;
		logic data_read;
		logic [2:0] low;
		logic [2:0] high;
		logic ovf;
		logic latch;
		logic [7:0] enable;
		logic [7:0] pins;
		logic [7:0] lower;
		logic [7:0] upper;
		logic [7:0] rdata;
	} mfi_state_s;

	mfi_state_s st;
	mfi_state_s next_st;

	mfi_cmp_if cmp_bus ();

	mfi_cmp u_cmp (
		.cmp_if(cmp_bus)
	);

	// packs the flags into the event_status layout
	function automatic logic [7:0] mfi_status_byte(input mfi_state_s s);
		logic [7:0] b;
		b = 8'h00;
		b[mfi_pkg::ST_LOW_X] = s.low[0];
		b[mfi_pkg::ST_LATCH] = s.latch;
		b[mfi_pkg::ST_LOW_Y] = s.low[1];
		b[mfi_pkg::ST_LOW_Z] = s.low[2];
		b[mfi_pkg::ST_HIGH_X] = s.high[0];
		b[mfi_pkg::ST_HIGH_Y] = s.high[1];
		b[mfi_pkg::ST_OVF] = s.ovf;
		b[mfi_pkg::ST_HIGH_Z] = s.high[2];
		mfi_status_byte = b;
	endfunction : mfi_status_byte

	// true for the field and resistance data registers
	function automatic logic mfi_is_data(input logic [7:0] a);
		mfi_is_data = (a >= mfi_pkg::ADDR_X_LSB) && (a <= mfi_pkg::ADDR_RES_MSB);
	endfunction : mfi_is_data

	// per-axis threshold enables are stored active low
	function automatic logic [2:0] mfi_axis_en(input logic [7:0] en, input int pos);
		mfi_axis_en = ~en[pos +: 3];
	endfunction : mfi_axis_en

	// polarity bit set means the active level is high
	function automatic logic mfi_pin_level(input logic active, input logic pol);
		mfi_pin_level = pol ? active : ~active;
	endfunction : mfi_pin_level

	// splits a 13-bit axis into its register bytes, low bits left aligned
	function automatic logic [7:0] mfi_xy_byte(input logic [mfi_pkg::XY_W-1:0] v, input logic upper);
		mfi_xy_byte = upper ? v[12:5] : {v[4:0], 3'h0};
	endfunction : mfi_xy_byte

	// next value of a group of event flags at a new measurement; a disabled
	// flag drops in both modes, an older flag survives only when latched
	function automatic logic [2:0] mfi_flags_next(
		input logic [2:0] held,
		input logic [2:0] hit,
		input logic [2:0] en,
		input logic latch
	);
		logic [2:0] keep;
		keep = latch ? held : 3'h0;
		mfi_flags_next = (keep | hit) & en;
	endfunction : mfi_flags_next

	// values to be stored, saturated on overflow
	logic [mfi_pkg::XY_W-1:0] new_x;
	logic [mfi_pkg::XY_W-1:0] new_y;
	logic [mfi_pkg::Z_W-1:0] new_z;
	logic [2:0] low_en;
	logic [2:0] high_en;
	logic ovf_en;
	logic status_read;
	logic data_read_now;
	logic event_active;
	logic [7:0] rd_mux;

	// engine outputs and clears
	logic [2:0] low_hit;
	logic [2:0] high_hit;
	logic ovf_hit;
	logic [2:0] ovf_next;
	logic flag_clear;
	logic ready_clear;

	always_comb begin
		new_x = meas_ovf_i[0] ? mfi_pkg::XY_OVF_MARK : meas_x_i;
		new_y = meas_ovf_i[1] ? mfi_pkg::XY_OVF_MARK : meas_y_i;
		new_z = meas_ovf_i[2] ? mfi_pkg::Z_OVF_MARK : meas_z_i;
	end

	// comparisons look at the values being stored, not the old ones
	assign cmp_bus.x = new_x;
	assign cmp_bus.y = new_y;
	assign cmp_bus.z = new_z;
	assign cmp_bus.low_thr = st.lower;
	assign cmp_bus.high_thr = st.upper;

	always_comb begin
		low_en = mfi_axis_en(st.enable, mfi_pkg::EN_LOW_N);
		high_en = mfi_axis_en(st.enable, mfi_pkg::EN_HIGH_N);
		ovf_en = st.enable[mfi_pkg::EN_OVF];
		status_read = reg_rd_i && (reg_addr_i == mfi_pkg::ADDR_EVENT_STATUS);
		data_read_now = reg_rd_i && mfi_is_data(reg_addr_i);
	end

	// the three flag engines; ready needs no gate since its pin enable does the job
	always_comb begin
		low_hit = cmp_bus.below & low_en;
		high_hit = cmp_bus.above & high_en;
		ovf_hit = (|meas_ovf_i) & ovf_en;
		flag_clear = status_read && st.latch;
		ready_clear = xfer_end_i && (st.data_read || data_read_now);
	end

	// read data mux, reserved bits read as zero
	always_comb begin
		rd_mux = 8'h00;
		unique case (reg_addr_i)
			mfi_pkg::ADDR_X_LSB: begin
				rd_mux = mfi_xy_byte(st.x, 1'b0);
			end
			mfi_pkg::ADDR_X_MSB: begin
				rd_mux = mfi_xy_byte(st.x, 1'b1);
			end
			mfi_pkg::ADDR_Y_LSB: begin
				rd_mux = mfi_xy_byte(st.y, 1'b0);
			end
			mfi_pkg::ADDR_Y_MSB: begin
				rd_mux = mfi_xy_byte(st.y, 1'b1);
			end
			mfi_pkg::ADDR_Z_LSB: begin
				rd_mux = {st.z[6:0], 1'h0};
			end
			mfi_pkg::ADDR_Z_MSB: begin
				rd_mux = st.z[14:7];
			end
			mfi_pkg::ADDR_READY_RES: begin
				rd_mux = {st.res[5:0], 2'h0};
				rd_mux[mfi_pkg::RDY_BIT] = st.ready;
			end
			mfi_pkg::ADDR_RES_MSB: begin
				rd_mux = st.res[13:6];
			end
			mfi_pkg::ADDR_EVENT_STATUS: begin
				rd_mux = mfi_status_byte(st);
			end
			mfi_pkg::ADDR_EVENT_ENABLE: begin
				rd_mux = st.enable;
			end
			mfi_pkg::ADDR_PIN_CONTROL: begin
				rd_mux = st.pins;
			end
			mfi_pkg::ADDR_LOWER_LIMIT: begin
				rd_mux = st.lower;
			end
			mfi_pkg::ADDR_UPPER_LIMIT: begin
				rd_mux = st.upper;
			end
			default: begin
				rd_mux = 8'h00;
			end
		endcase
	end

	always_comb begin
		next_st = st;
		ovf_next = 3'h0;

		// read data is registered; a read takes the value before any clear
		if (reg_rd_i) begin
			next_st.rdata = rd_mux;
		end

		// register writes; addresses up to 0x4A are read-only except the mode bit
		if (reg_wr_i) begin
			unique case (reg_addr_i)
				mfi_pkg::ADDR_EVENT_STATUS: begin
					next_st.latch = reg_wdata_i[mfi_pkg::ST_LATCH];
				end
				mfi_pkg::ADDR_EVENT_ENABLE: begin
					next_st.enable = reg_wdata_i;
				end
				mfi_pkg::ADDR_PIN_CONTROL: begin
					next_st.pins = reg_wdata_i;
				end
				mfi_pkg::ADDR_LOWER_LIMIT: begin
					next_st.lower = reg_wdata_i;
				end
				mfi_pkg::ADDR_UPPER_LIMIT: begin
					next_st.upper = reg_wdata_i;
				end
				default: begin
				end
			endcase
		end

		// latched flags drop on a status read; the pin follows the flags
		if (flag_clear) begin
			next_st.low = 3'h0;
			next_st.high = 3'h0;
			next_st.ovf = 1'b0;
		end

		// ready clears when a transfer that touched data registers ends
		if (data_read_now) begin
			next_st.data_read = 1'b1;
		end
		if (ready_clear) begin
			next_st.ready = 1'b0;
			next_st.data_read = 1'b0;
		end

		// a new set is stored and every flag is recomputed in the same edge;
		// placed last so a same-cycle clear never hides a fresh event
		if (meas_valid_i) begin
			next_st.x = new_x;
			next_st.y = new_y;
			next_st.z = new_z;
			next_st.res = meas_res_i;
			next_st.ready = 1'b1;
			next_st.low = mfi_flags_next(next_st.low, low_hit, low_en, st.latch);
			next_st.high = mfi_flags_next(next_st.high, high_hit, high_en, st.latch);
			// overflow reuses the three-lane helper in its lowest lane
			ovf_next = mfi_flags_next({2'h0, next_st.ovf}, {2'h0, ovf_hit}, {2'h0, ovf_en}, st.latch);
			next_st.ovf = ovf_next[0];
		end

		if (sys_rst_i) begin
			next_st = '0;
			next_st.latch = mfi_pkg::LATCH_RST;
			next_st.enable = mfi_pkg::ENABLE_RST;
			next_st.pins = mfi_pkg::PIN_RST;
			next_st.lower = mfi_pkg::LIMIT_RST;
			next_st.upper = mfi_pkg::LIMIT_RST;
		end
	end

	always_ff @(posedge clk_i) begin
		st <= next_st;
	end

	// pins are decoded from registered state only, so they never glitch on inputs
	always_comb begin
		event_active = (|st.low) | (|st.high) | st.ovf;
		event_pin_o = mfi_pin_level(event_active, st.pins[mfi_pkg::PC_EVENT_POL]);
		event_pin_oe_o = st.pins[mfi_pkg::PC_EVENT_EN];
	end

	// the ready pin is kept apart from the shared event pin
	always_comb begin
		sample_ready_pin_o = mfi_pin_level(st.ready, st.pins[mfi_pkg::PC_READY_POL]);
		sample_ready_pin_oe_o = st.pins[mfi_pkg::PC_READY_EN];
	end

	assign reg_rdata_o = st.rdata;
	assign field_x_value_o = st.x;
	assign field_y_value_o = st.y;
	assign field_z_value_o = st.z;
	assign plate_resistance_value_o = st.res;

endmodule : mfi_ctrl
`default_nettype wire

// [inc/mfi_cmp_if.sv]
// Purpose: carries the field values about to be stored to the threshold comparator
// Assumes: one clock domain, purely combinational path
// Notes: below and above are per axis, bit0 x, bit1 y, bit2 z
`timescale 1ns/1ps
`default_nettype none
interface mfi_cmp_if;
	logic [mfi_pkg::XY_W-1:0] x;
	logic [mfi_pkg::XY_W-1:0] y;
	logic [mfi_pkg::Z_W-1:0] z;
	logic [7:0] low_thr;
	logic [7:0] high_thr;
	logic [2:0] below;
	logic [2:0] above;
	modport ctrl (output x, output y, output z, output low_thr, output high_thr, input below, input above);
	modport cmp (input x, input y, input z, input low_thr, input high_thr, output below, output above);
endinterface : mfi_cmp_if
`default_nettype wire

// [inc/mfi_pkg.sv]
// Purpose: shared constants of the magnetic field interrupt controller
// Assumes: 8-bit registers at byte offsets, field values in two's complement
// Notes: status byte layout shares 0x4A with the latch mode bit
package mfi_pkg;

	// field widths
	localparam int XY_W = 13;
	localparam int Z_W = 15;
	localparam int RES_W = 14;
	localparam int CMP_W = 16;

	// register offsets
	localparam logic [7:0] ADDR_X_LSB = 8'h42;
	localparam logic [7:0] ADDR_X_MSB = 8'h43;
	localparam logic [7:0] ADDR_Y_LSB = 8'h44;
	localparam logic [7:0] ADDR_Y_MSB = 8'h45;
	localparam logic [7:0] ADDR_Z_LSB = 8'h46;
	localparam logic [7:0] ADDR_Z_MSB = 8'h47;
	localparam logic [7:0] ADDR_READY_RES = 8'h48;
	localparam logic [7:0] ADDR_RES_MSB = 8'h49;
	localparam logic [7:0] ADDR_EVENT_STATUS = 8'h4A;
	localparam logic [7:0] ADDR_EVENT_ENABLE = 8'h4D;
	localparam logic [7:0] ADDR_PIN_CONTROL = 8'h4E;
	localparam logic [7:0] ADDR_LOWER_LIMIT = 8'h4F;
	localparam logic [7:0] ADDR_UPPER_LIMIT = 8'h50;

	// event_status bit positions
	localparam int ST_LOW_X = 0;
	localparam int ST_LATCH = 1;
	localparam int ST_LOW_Y = 2;
	localparam int ST_LOW_Z = 3;
	localparam int ST_HIGH_X = 4;
	localparam int ST_HIGH_Y = 5;
	localparam int ST_OVF = 6;
	localparam int ST_HIGH_Z = 7;

	// event_enable bit positions, threshold enables are active low
	localparam int EN_LOW_N = 0;
	localparam int EN_HIGH_N = 3;
	localparam int EN_OVF = 6;

	// pin_control bit positions
	localparam int PC_EVENT_POL = 0;
	localparam int PC_READY_POL = 2;
	localparam int PC_EVENT_EN = 6;
	localparam int PC_READY_EN = 7;

	// sample_ready_and_resistance_low layout
	localparam int RDY_BIT = 0;
	localparam int RES_LSB_POS = 2;

	// values after reset
	localparam logic [7:0] ENABLE_RST = 8'h3F;
	localparam logic [7:0] PIN_RST = 8'h05;
	localparam logic [7:0] LIMIT_RST = 8'h00;
	localparam logic LATCH_RST = 1'b1;

	// saturation markers and threshold scale
	localparam logic [XY_W-1:0] XY_OVF_MARK = 13'h1000;
	localparam logic [Z_W-1:0] Z_OVF_MARK = 15'h4000;
	localparam int THR_SHIFT = 4;

endpackage : mfi_pkg
